/* verilog/modbus_service_regs.sv */
// service and flow register bank of the serial gateway, slave side
// assumes decoded holding-register requests from the serial front end,
// switch and actuator inputs synchronous to REF_CLK_IN
module modbus_service_regs #(
    parameter int CYCLES_PER_MS = svc_regs_pkg::CYCLES_PER_MS_DEF,
    // value is arbitrary
    parameter logic [15:0] FW_REVISION = 16'h0100
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // configuration switches
    input wire logic [2:0] BAUD_SW_IN,
    input wire logic [7:0] ADDR_SW_IN,
    input wire logic PARITY_EVEN_SW_IN,
    // tool socket
    input wire logic TOOL_DETECT_IN,
    // addressed actuator
    input wire logic [3:0] ACT_TYPE_IN,
    input wire logic VALVE_UNIT_IN,
    input wire logic STATIC_PRESSURE_MODE_IN,
    input wire logic [15:0] ABS_FLOW_IN,
    input wire logic [15:0] NOM_FLOW_IN,
    // register request
    input wire logic REQ_VALID_IN,
    input wire logic REQ_WRITE_IN,
    input wire logic [15:0] REQ_REG_IN,
    input wire logic [15:0] REQ_WDATA_IN,
    // register answer
    output logic BUSY_OUT,
    output logic RSP_VALID_OUT,
    output logic RSP_ERR_OUT,
    output logic [15:0] RSP_DATA_OUT,
    // serial configuration, field bus and flow unit
    output logic [15:0] BAUD_DIV100_OUT,
    output logic [7:0] SLAVE_ADDR_OUT,
    output logic PARITY_EVEN_OUT,
    output logic STOP_TWO_OUT,
    output logic FIELDBUS_SUSPEND_OUT,
    output svc_regs_pkg::flow_unit_t FLOW_UNIT_OUT
);
    svc_regs_pkg::rsp_state_t state_q, state_d;
    logic [15:0] delay_q;
    logic [15:0] eff_ms_q;
    logic [15:0] data_d;
    logic err_d;
    logic take;
    logic timer_done;
    logic [15:0] abs_val, nom_val;
    svc_regs_pkg::flow_unit_t nom_unit;
    logic [15:0] baud_val;
    logic [7:0] addr_val;
    logic is_9600;
    logic [15:0] eff_ms;
    logic delay_ok;
    logic delay_wr;

    // requests arriving while busy are dropped, not queued
    assign take = REQ_VALID_IN && (state_q == svc_regs_pkg::ST_IDLE);

    assign baud_val = svc_regs_pkg::BAUD_TABLE[BAUD_SW_IN];
    assign is_9600 = (baud_val == svc_regs_pkg::BAUD_9600_DIV100);

    assign addr_val = (ADDR_SW_IN < svc_regs_pkg::ADDR_MIN) ? svc_regs_pkg::ADDR_MIN :
                      (ADDR_SW_IN > svc_regs_pkg::ADDR_MAX) ? svc_regs_pkg::ADDR_MAX :
                      ADDR_SW_IN;

    // a delay write counts from the next request on, not the writing one
    // fixed delay at 9600
    assign eff_ms = is_9600 ? svc_regs_pkg::DELAY_FIXED_MS : delay_q;

    // out-of-range delay writes are refused, not clipped
    assign delay_ok = (REQ_WDATA_IN >= svc_regs_pkg::DELAY_MIN_MS) &&
                      (REQ_WDATA_IN <= svc_regs_pkg::DELAY_MAX_MS);
    assign delay_wr = take && REQ_WRITE_IN && (REQ_REG_IN == svc_regs_pkg::REG_DELAY) && delay_ok;

    flow_value_gate u_abs_gate (
        .act_type_in(ACT_TYPE_IN),
        .valve_unit_in(VALVE_UNIT_IN),
        .static_pressure_mode_in(STATIC_PRESSURE_MODE_IN),
        .raw_in(ABS_FLOW_IN),
        .value_out(abs_val),
        .unit_out()
    );

    flow_value_gate u_nom_gate (
        .act_type_in(ACT_TYPE_IN),
        .valve_unit_in(VALVE_UNIT_IN),
        .static_pressure_mode_in(STATIC_PRESSURE_MODE_IN),
        .raw_in(NOM_FLOW_IN),
        .value_out(nom_val),
        .unit_out(nom_unit)
    );

    always_comb begin
        data_d = 16'h0000;
        err_d = 1'b0;
        if (REQ_WRITE_IN) begin
            err_d = !((REQ_REG_IN == svc_regs_pkg::REG_DELAY) && delay_ok);
        end else begin
            case (REQ_REG_IN)
                svc_regs_pkg::REG_ABS_FLOW: data_d = abs_val;
                svc_regs_pkg::REG_NOM_FLOW: data_d = nom_val;
                svc_regs_pkg::REG_BAUD: data_d = baud_val;
                svc_regs_pkg::REG_ADDR: data_d = {8'h00, addr_val};
                svc_regs_pkg::REG_DELAY: data_d = eff_ms;
                svc_regs_pkg::REG_FW: data_d = FW_REVISION;
                default: err_d = 1'b1;
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            svc_regs_pkg::ST_IDLE: if (take) state_d = svc_regs_pkg::ST_WAIT;
            svc_regs_pkg::ST_WAIT: if (timer_done) state_d = svc_regs_pkg::ST_IDLE;
            default: state_d = svc_regs_pkg::ST_IDLE;
        endcase
    end

    reply_delay_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .start_in(take),
        .delay_ms_in(eff_ms),
        .done_out(timer_done)
    );

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= svc_regs_pkg::ST_IDLE;
            delay_q <= svc_regs_pkg::DELAY_RESET_MS;
            eff_ms_q <= svc_regs_pkg::DELAY_RESET_MS;
            BUSY_OUT <= 1'b0;
            RSP_VALID_OUT <= 1'b0;
            RSP_ERR_OUT <= 1'b0;
            RSP_DATA_OUT <= 16'h0000;
        end else begin
            state_q <= state_d;
            BUSY_OUT <= (state_d != svc_regs_pkg::ST_IDLE);
            RSP_VALID_OUT <= (state_q == svc_regs_pkg::ST_WAIT) && timer_done;
            if (delay_wr) delay_q <= REQ_WDATA_IN;
            // answer frozen at take, later input changes cannot tear it
            if (take) begin
                eff_ms_q <= eff_ms;
                RSP_DATA_OUT <= data_d;
                RSP_ERR_OUT <= err_d;
            end
        end
    end

    // status and pin-facing outputs, one flop each
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            BAUD_DIV100_OUT <= 16'h0000;
            SLAVE_ADDR_OUT <= 8'h00;
            PARITY_EVEN_OUT <= 1'b0;
            STOP_TWO_OUT <= 1'b1;
            FIELDBUS_SUSPEND_OUT <= 1'b1;
            FLOW_UNIT_OUT <= svc_regs_pkg::UNIT_NONE;
        end else begin
            BAUD_DIV100_OUT <= baud_val;
            SLAVE_ADDR_OUT <= addr_val;
            PARITY_EVEN_OUT <= PARITY_EVEN_SW_IN;
            STOP_TWO_OUT <= !PARITY_EVEN_SW_IN;
            FIELDBUS_SUSPEND_OUT <= TOOL_DETECT_IN;
            FLOW_UNIT_OUT <= nom_unit;
        end
    end

    // helpers read only by the checks below
    logic [31:0] wait_cnt_q;
    logic first_q;
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wait_cnt_q <= 32'h0000_0000;
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
            if (take) wait_cnt_q <= 32'h0000_0000;
            else if (state_q == svc_regs_pkg::ST_WAIT) wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_nom_flow_gate: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_NOM_FLOW &&
        ACT_TYPE_IN != svc_regs_pkg::ACT_TYPE_FLOW |=> RSP_DATA_OUT == 16'hFFFF && !RSP_ERR_OUT)
        else $error("nominal flow not blanked for other category");
    a_flow_unit_map: assert property (
        ACT_TYPE_IN == svc_regs_pkg::ACT_TYPE_FLOW && !VALVE_UNIT_IN && STATIC_PRESSURE_MODE_IN
        |=> FLOW_UNIT_OUT == svc_regs_pkg::UNIT_PA)
        else $error("static pressure unit wrong");
    a_baud_readback: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_BAUD
        |=> RSP_DATA_OUT == svc_regs_pkg::BAUD_TABLE[$past(BAUD_SW_IN)])
        else $error("baud register does not follow switches");
    a_addr_range: assert property (
        !first_q |-> SLAVE_ADDR_OUT >= svc_regs_pkg::ADDR_MIN &&
        SLAVE_ADDR_OUT <= svc_regs_pkg::ADDR_MAX)
        else $error("slave address out of range");
    a_delay_reset: assert property (
        first_q |-> delay_q == svc_regs_pkg::DELAY_RESET_MS)
        else $error("reply delay not 2 ms after reset");
    a_delay_length: assert property (
        timer_done && state_q == svc_regs_pkg::ST_WAIT
        |-> wait_cnt_q == 32'(eff_ms_q) * 32'(CYCLES_PER_MS))
        else $error("reply delay length wrong");
    a_fixed_9600: assert property (
        take && is_9600 |=> eff_ms_q == svc_regs_pkg::DELAY_FIXED_MS)
        else $error("9600 baud delay not fixed");
    a_tool_suspend: assert property (
        TOOL_DETECT_IN ##1 TOOL_DETECT_IN |-> FIELDBUS_SUSPEND_OUT)
        else $error("field bus not suspended with tool attached");
    a_char_format: assert property (
        !first_q |-> PARITY_EVEN_OUT != STOP_TWO_OUT)
        else $error("illegal character format");
    a_svc_decode: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN >= 16'h00A1 && REQ_REG_IN <= 16'h00A4
        |=> RSP_ERR_OUT)
        else $error("old service location still answers");
    a_fw_read: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_FW
        |=> RSP_DATA_OUT == FW_REVISION && !RSP_ERR_OUT)
        else $error("firmware revision not returned");
    a_abs_flow_gate: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_ABS_FLOW &&
        ACT_TYPE_IN != svc_regs_pkg::ACT_TYPE_FLOW |=> RSP_DATA_OUT == 16'hFFFF)
        else $error("absolute flow not blanked for other category");
    a_one_word_reply: assert property (
        RSP_VALID_OUT |-> !BUSY_OUT ##1 !RSP_VALID_OUT)
        else $error("answer longer than one cycle");
    a_busy_after_take: assert property (
        take |=> BUSY_OUT)
        else $error("busy not raised after request");
    a_nom_flow_pass: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_NOM_FLOW &&
        ACT_TYPE_IN == svc_regs_pkg::ACT_TYPE_FLOW |=> RSP_DATA_OUT == $past(NOM_FLOW_IN))
        else $error("nominal flow not passed for flow category");
    a_abs_flow_pass: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_ABS_FLOW &&
        ACT_TYPE_IN == svc_regs_pkg::ACT_TYPE_FLOW |=> RSP_DATA_OUT == $past(ABS_FLOW_IN))
        else $error("absolute flow not passed for flow category");
    a_unit_valve: assert property (
        ACT_TYPE_IN == svc_regs_pkg::ACT_TYPE_FLOW && VALVE_UNIT_IN
        |=> FLOW_UNIT_OUT == svc_regs_pkg::UNIT_LMIN)
        else $error("valve unit wrong");
    a_unit_m3h: assert property (
        ACT_TYPE_IN == svc_regs_pkg::ACT_TYPE_FLOW && !VALVE_UNIT_IN && !STATIC_PRESSURE_MODE_IN
        |=> FLOW_UNIT_OUT == svc_regs_pkg::UNIT_M3H)
        else $error("flow controller unit wrong");
    a_unit_none: assert property (
        ACT_TYPE_IN != svc_regs_pkg::ACT_TYPE_FLOW
        |=> FLOW_UNIT_OUT == svc_regs_pkg::UNIT_NONE)
        else $error("unit given for other category");
    a_baud_status: assert property (
        1'b1 |=> BAUD_DIV100_OUT == svc_regs_pkg::BAUD_TABLE[$past(BAUD_SW_IN)])
        else $error("baud status does not follow switches");
    a_addr_readback: assert property (
        take && !REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_ADDR
        |=> RSP_DATA_OUT[15:8] == 8'h00 && RSP_DATA_OUT[7:0] >= svc_regs_pkg::ADDR_MIN &&
        RSP_DATA_OUT[7:0] <= svc_regs_pkg::ADDR_MAX && !RSP_ERR_OUT)
        else $error("address register out of range");
    a_delay_write: assert property (
        delay_wr |=> delay_q == $past(REQ_WDATA_IN))
        else $error("accepted delay not stored");
    a_delay_refuse: assert property (
        take && REQ_WRITE_IN && REQ_REG_IN == svc_regs_pkg::REG_DELAY && !delay_ok
        |=> RSP_ERR_OUT && $stable(delay_q))
        else $error("bad delay value not refused");
    a_delay_program: assert property (
        take && !is_9600 |=> eff_ms_q == $past(delay_q))
        else $error("programmed delay not used");
    a_tool_release: assert property (
        !TOOL_DETECT_IN ##1 !TOOL_DETECT_IN |-> !FIELDBUS_SUSPEND_OUT)
        else $error("field bus suspended without tool");
    a_parity_follow: assert property (
        1'b1 |=> PARITY_EVEN_OUT == $past(PARITY_EVEN_SW_IN))
        else $error("parity does not follow switch");
    a_ro_write_err: assert property (
        take && REQ_WRITE_IN && REQ_REG_IN != svc_regs_pkg::REG_DELAY |=> RSP_ERR_OUT)
        else $error("write to read-only register accepted");

    c_nom_read: cover property (take && REQ_REG_IN == svc_regs_pkg::REG_NOM_FLOW);
    c_delay_write: cover property (delay_wr);
    c_reply_9600: cover property (RSP_VALID_OUT && eff_ms_q == svc_regs_pkg::DELAY_FIXED_MS);
    c_error_reply: cover property (RSP_VALID_OUT && RSP_ERR_OUT);
    c_tool_attached: cover property ($rose(FIELDBUS_SUSPEND_OUT));
endmodule // modbus_service_regs

/* verilog/svc_regs_pkg.sv */
// constants for the gateway service and flow register bank
// assumes a 100 MHz reference clock and register numbers as seen by the serial master
package svc_regs_pkg;

    // register numbers
    localparam logic [15:0] REG_ABS_FLOW = 16'h0010;
    localparam logic [15:0] REG_NOM_FLOW = 16'h0011;
    localparam logic [15:0] REG_BAUD = 16'h03E9;
    localparam logic [15:0] REG_ADDR = 16'h03EA;
    localparam logic [15:0] REG_DELAY = 16'h03EB;
    localparam logic [15:0] REG_FW = 16'h03EC;

    // flow availability
    localparam logic [15:0] FLOW_NOT_AVAIL = 16'hFFFF;
    localparam logic [3:0] ACT_TYPE_FLOW = 4'h5;

    // reply delay in ms
    localparam logic [15:0] DELAY_RESET_MS = 16'h0002;
    localparam logic [15:0] DELAY_MIN_MS = 16'h0002;
    localparam logic [15:0] DELAY_MAX_MS = 16'h0064;
    localparam logic [15:0] DELAY_FIXED_MS = 16'h0004;

    // slave address range
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'hF7;

    // baud rate divided by 100, indexed by the switch code
    localparam logic [15:0] BAUD_9600_DIV100 = 16'h0060;
    localparam logic [15:0] BAUD_TABLE [0:7] = '{
        16'h0060, 16'h00C0, 16'h0180, 16'h0240,
        16'h0480, 16'h0060, 16'h0060, 16'h0060
    };

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_IN_NS = 1000000;
    localparam int CYCLES_PER_MS_DEF = MS_IN_NS / CLK_PERIOD_NS;

    // units of the flow registers
    typedef enum logic [1:0] {
        UNIT_NONE = 2'b00,
        UNIT_M3H = 2'b01,
        UNIT_PA = 2'b10,
        UNIT_LMIN = 2'b11
    } flow_unit_t;

    // reply sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } rsp_state_t;

endpackage

/* verilog/flow_value_gate.sv */
// gates one flow register by actuator category and gives its unit
// assumes actuator information is stable while it is sampled
module flow_value_gate (
    // actuator description
    input wire logic [3:0] act_type_in,
    input wire logic valve_unit_in,
    input wire logic static_pressure_mode_in,
    // raw and gated value
    input wire logic [15:0] raw_in,
    output logic [15:0] value_out,
    output svc_regs_pkg::flow_unit_t unit_out
);
    logic is_flow_type;
    assign is_flow_type = (act_type_in == svc_regs_pkg::ACT_TYPE_FLOW);

    assign value_out = is_flow_type ? raw_in : svc_regs_pkg::FLOW_NOT_AVAIL;

    assign unit_out = !is_flow_type ? svc_regs_pkg::UNIT_NONE :
                      valve_unit_in ? svc_regs_pkg::UNIT_LMIN :
                      static_pressure_mode_in ? svc_regs_pkg::UNIT_PA :
                      svc_regs_pkg::UNIT_M3H;
endmodule // flow_value_gate

/* verilog/reply_delay_timer.sv */
// counts a reply delay in whole milliseconds, then pulses done
// assumes start only while idle and delay_ms of at least one
module reply_delay_timer #(
    parameter int CYCLES_PER_MS = svc_regs_pkg::CYCLES_PER_MS_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic start_in,
    input wire logic [15:0] delay_ms_in,
    output logic done_out
);
    localparam int PW = $clog2(CYCLES_PER_MS + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);

    logic run_q;
    logic [PW-1:0] pre_q;
    logic [15:0] ms_left_q;
    logic wrap;
    logic last_ms;

    assign wrap = run_q && (pre_q == PRE_LAST);
    assign last_ms = (ms_left_q == 16'h0001);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= 1'b0;
            pre_q <= '0;
            ms_left_q <= 16'h0000;
            done_out <= 1'b0;
        end else begin
            done_out <= wrap && last_ms;
            if (start_in) begin
                run_q <= 1'b1;
                pre_q <= '0;
                ms_left_q <= delay_ms_in;
            end else if (wrap) begin
                pre_q <= '0;
                ms_left_q <= ms_left_q - 16'h0001;
                run_q <= !last_ms;
            end else if (run_q) begin
                pre_q <= pre_q + PW'(1);
            end
        end
    end
endmodule // reply_delay_timer

/* testbench/modbus_master_model.sv */
// serial master model issuing holding-register requests to the bank
// assumes the caller enters xfer 1 ns after a rising edge of clk_in
module modbus_master_model (
    // clock
    input wire logic clk_in,
    // answer from the bank
    input wire logic busy_in,
    input wire logic rsp_valid_in,
    input wire logic rsp_err_in,
    input wire logic [15:0] rsp_data_in,
    // request to the bank
    output logic req_valid_out,
    output logic req_write_out,
    output logic [15:0] req_reg_out,
    output logic [15:0] req_wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid_out = 1'b0;
        req_write_out = 1'b0;
        req_reg_out = 16'h0000;
        req_wdata_out = 16'h0000;
    end

    // reply delay is raised by the caller
    task automatic xfer(input logic wr, input logic [15:0] rg, input logic [15:0] wd,
                        output logic [15:0] rd, output logic er, output int lat);
        int n;
        n = 0;
        req_valid_out = 1'b1;
        req_write_out = wr;
        req_reg_out = rg;
        req_wdata_out = wd;
        while (busy_in !== 1'b0 && n < 2000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        #1;
        // released lines show the inverse, never a stale copy
        req_valid_out = 1'b0;
        req_write_out = ~wr;
        req_reg_out = ~rg;
        req_wdata_out = ~wd;
        n = 0;
        while (rsp_valid_in !== 1'b1 && n < 2000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        rd = rsp_data_in;
        er = rsp_err_in;
        lat = n;
    endtask
endmodule // modbus_master_model

/* testbench/tb.sv */
// self-checking bench of the service and flow register bank
// assumes the master model drives requests; switches and actuator come from here
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CPM = 4;
    // value is arbitrary
    localparam logic [15:0] FW_REV = 16'h3A7C;
    logic clk = 1'b0;
    logic rst_n, par_sw, tool, valve, spm, busy, rsp_valid, rsp_err;
    logic par_out, stop2_out, susp_out, req_valid, req_write;
    logic [2:0] baud_sw;
    logic [7:0] addr_sw, addr_out;
    logic [3:0] act_type;
    logic [15:0] abs_flow, nom_flow, rsp_data, baud_out, req_reg, req_wdata;
    svc_regs_pkg::flow_unit_t unit_out;
    logic [31:0] seed;
    logic [7:0] corner [0:4] = '{8'h00, 8'h01, 8'hF7, 8'hF8, 8'hFF};
    int fail_count = 0;
    int n_compared = 0;
    int dly_ms = 2;

    always #5 clk = ~clk;

    modbus_service_regs #(.CYCLES_PER_MS(CPM), .FW_REVISION(FW_REV)) DUT (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .BAUD_SW_IN(baud_sw), .ADDR_SW_IN(addr_sw),
        .PARITY_EVEN_SW_IN(par_sw), .TOOL_DETECT_IN(tool), .ACT_TYPE_IN(act_type),
        .VALVE_UNIT_IN(valve), .STATIC_PRESSURE_MODE_IN(spm), .ABS_FLOW_IN(abs_flow),
        .NOM_FLOW_IN(nom_flow), .REQ_VALID_IN(req_valid), .REQ_WRITE_IN(req_write),
        .REQ_REG_IN(req_reg), .REQ_WDATA_IN(req_wdata), .BUSY_OUT(busy),
        .RSP_VALID_OUT(rsp_valid), .RSP_ERR_OUT(rsp_err), .RSP_DATA_OUT(rsp_data),
        .BAUD_DIV100_OUT(baud_out), .SLAVE_ADDR_OUT(addr_out), .PARITY_EVEN_OUT(par_out),
        .STOP_TWO_OUT(stop2_out), .FIELDBUS_SUSPEND_OUT(susp_out), .FLOW_UNIT_OUT(unit_out)
    );

    modbus_master_model m (
        .clk_in(clk), .busy_in(busy), .rsp_valid_in(rsp_valid), .rsp_err_in(rsp_err),
        .rsp_data_in(rsp_data), .req_valid_out(req_valid), .req_write_out(req_write),
        .req_reg_out(req_reg), .req_wdata_out(req_wdata)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
    endfunction

    function automatic logic is9600(input logic [2:0] c);
        return (c == 3'h0) || (c > 3'h4);
    endfunction

    function automatic logic [15:0] baud_exp(input logic [2:0] c);
        case (c)
            3'h1: return 16'h00C0;
            3'h2: return 16'h0180;
            3'h3: return 16'h0240;
            3'h4: return 16'h0480;
            default: return 16'h0060;
        endcase
    endfunction

    function automatic logic [7:0] addr_exp(input logic [7:0] a);
        return (a == 8'h00) ? 8'h01 : ((a > 8'hF7) ? 8'hF7 : a);
    endfunction

    function automatic logic [1:0] unit_exp();
        if (act_type != 4'h5) begin
            return 2'h0;
        end
        return valve ? 2'h3 : (spm ? 2'h2 : 2'h1);
    endfunction

    function automatic logic [15:0] flow_exp(input logic [15:0] v);
        return (act_type == 4'h5) ? v : 16'hFFFF;
    endfunction

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xact(input logic wr, input logic [15:0] rg, input logic [15:0] wd,
                        input logic [15:0] ed, input logic ee);
        logic [15:0] rd;
        logic er;
        int lat;
        int d;
        d = is9600(baud_sw) ? 4 : dly_ms;
        m.xfer(wr, rg, wd, rd, er, lat);
        chk(rd, ed);
        chk(er, ee);
        chk(lat, d * CPM + 1);
        chk(busy, 1'b0);
    endtask

    task automatic print_verdict();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        {par_sw, tool, valve, spm, act_type} = 8'h00;
        baud_sw = 3'h1;
        addr_sw = 8'h10;
        abs_flow = 16'h0000;
        nom_flow = 16'h0000;
        seed = 32'hC82EB4C7;
        step(2);
        chk(susp_out, 1'b1);
        chk(stop2_out, 1'b1);
        rst_n = 1'b1;
        step(2);
        xact(1'b0, 16'h03EB, 16'h0000, 16'h0002, 1'b0);
        xact(1'b0, 16'h03EC, 16'h0000, FW_REV, 1'b0);
        for (int r = 161; r <= 164; r++) begin
            xact(1'b0, 16'(r), 16'h0000, 16'h0000, 1'b1);
        end
        xact(1'b0, 16'h0012, 16'h0000, 16'h0000, 1'b1);
        xact(1'b1, 16'h03EB, 16'h0005, 16'h0000, 1'b0);
        dly_ms = 5;
        xact(1'b0, 16'h03EB, 16'h0000, 16'h0005, 1'b0);
        xact(1'b1, 16'h03EB, 16'h0001, 16'h0000, 1'b1);
        xact(1'b1, 16'h03EB, 16'h0065, 16'h0000, 1'b1);
        xact(1'b1, 16'h03E9, 16'h0007, 16'h0000, 1'b1);
        xact(1'b1, 16'h03EB, 16'h0064, 16'h0000, 1'b0);
        dly_ms = 100;
        xact(1'b1, 16'h03EB, 16'h0002, 16'h0000, 1'b0);
        dly_ms = 2;
        for (int i = 0; i < 8; i++) begin
            baud_sw = 3'(i);
            step(1);
            chk(baud_out, baud_exp(baud_sw));
            xact(1'b0, 16'h03E9, 16'h0000, baud_exp(baud_sw), 1'b0);
            xact(1'b0, 16'h03EB, 16'h0000, is9600(baud_sw) ? 16'h4 : 16'h2, 1'b0);
        end
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            addr_sw = (i < 5) ? corner[i] : seed[7:0];
            step(1);
            chk(addr_out, addr_exp(addr_sw));
            xact(1'b0, 16'h03EA, 16'h0000, {8'h00, addr_exp(addr_sw)}, 1'b0);
        end
        for (int i = 0; i < 2; i++) begin
            par_sw = i[0];
            tool = i[0];
            step(1);
            chk(par_out, i[0]);
            chk(stop2_out, !i[0]);
            chk(susp_out, i[0]);
        end
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            act_type = (i < 4) ? 4'h5 : seed[3:0];
            valve = (i < 4) ? i[0] : seed[4];
            spm = (i < 4) ? i[1] : seed[5];
            nom_flow = seed[31:16];
            abs_flow = seed[21:6];
            step(1);
            chk(unit_out, unit_exp());
            xact(1'b0, 16'h0011, 16'h0000, flow_exp(nom_flow), 1'b0);
            xact(1'b0, 16'h0010, 16'h0000, flow_exp(abs_flow), 1'b0);
        end
        print_verdict();
    end
endmodule // tb
